// ### core/system_mgmt_mode_sequencer.sv
/*
  Management mode entry and exit sequencer for one processor core.
  Assumes the core pipeline signals instruction boundaries and return
  instruction execution, and that a save engine writes or reads the whole
  state image in one handshake.
*/
// Summary of operation
// - Enter only at next instruction boundary.
// - Optional special cycles on entry and exit.
// - Save state first, then jump to handler.
// - Return restores state, resumes after entry.
// - Handler entry at base plus 8000h.
// - Save area spans base+FE00h to FFFFh.
// - Real mode, 4G limits, 16-bit defaults.
// - IP truncated 16 bits, far base 20.
// - Address bit 20 mask ignored inside mode.
// - Clear IF and TF, mask NMI, INIT.
// - DR7 loaded with 400h on entry.
// - Real-mode vector table during management mode.
// - Accept only SMI link messages matching destination or broadcast.
// - Local events issue IO cycle, not SMI.
// - Listed local sources trigger cycle, set status.
// - Pending and halt events issue own cycles unless a local event rises too.
// - Start base+8000h, CS base[19:4], others zero.
// - Flags 2, CR4 zero, rest unmodified.
// - Clear CR0 bits 0, 2, 3, 31.
// - Clear EFER except bit 12.
// - Save offsets relative to region base register.
`timescale 1ns/100ps
module system_mgmt_mode_sequencer #(
  parameter int ADDR_W = 32
) (
  // Clock and reset.
  input  wire logic                      ref_clk_i,
  input  wire logic                      resetn_i,
  // Link interrupt messages and node identity.
  input  wire smm_seq_pkg::int_msg_t     msg_i,
  input  wire logic [7:0]                node_id_i,
  // Configuration.
  input  wire logic [ADDR_W-1:0]         region_base_msr_i,
  input  wire logic                      special_cycle_en_i,
  input  wire logic [47:0]               trigger_io_cycle_reg_i,
  input  wire logic [47:0]               pending_halt_event_reg_i,
  // Local events.
  input  wire logic [smm_seq_pkg::NUM_SRC-1:0] local_event_i,
  input  wire logic                      pend_halt_event_i,
  // Core pipeline.
  input  wire logic                      insn_boundary_i,
  input  wire logic                      rsm_exec_i,
  input  wire smm_seq_pkg::arch_state_t  core_state_i,
  input  wire logic                      address_bit20_mask_pin_i,
  // Save engine.
  input  wire logic                      save_done_i,
  input  wire smm_seq_pkg::arch_state_t  restore_state_i,
  // Save engine requests.
  output logic                           save_req_o,
  output logic                           restore_req_o,
  output logic [ADDR_W-1:0]              save_addr_o,
  output smm_seq_pkg::arch_state_t       save_state_o,
  // State loaded into the core and fetch target.
  output logic                           load_state_o,
  output smm_seq_pkg::arch_state_t       load_state_val_o,
  output logic [ADDR_W-1:0]              fetch_addr_o,
  // Mode controls to the core.
  output logic                           in_smm_o,
  output logic                           real_mode_o,
  output logic                           default_16bit_o,
  output logic [31:0]                    seg_limit_o,
  output logic [4:0]                     ip_width_sel_o,
  output logic [4:0]                     far_base_bits_o,
  output logic                           a20_mask_eff_o,
  output logic                           nmi_init_masked_o,
  output logic                           real_ivt_sel_o,
  // Outgoing bus cycles and status.
  output smm_seq_pkg::io_cycle_t         io_cycle_o,
  output logic                           special_enter_o,
  output logic                           special_exit_o,
  output logic [31:0]                    local_smi_status_o
);

  // The offsets are 32-bit constants, so a wider base cannot be served, and the
  // code selector needs base bits up to 19.
  if (ADDR_W < 20 || ADDR_W > 32) begin : g_addr_w_check
    $error("ADDR_W must lie between 20 and 32");
  end

  // One-hot sequencer states; a stray code falls back to idle.
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_WAIT    = 5'b00010,
    ST_SAVE    = 5'b00100,
    ST_HANDLER = 5'b01000,
    ST_RESTORE = 5'b10000
  } seq_state_t;

  // Sequencer state, synchronised pin and event history.
  seq_state_t  state;
  seq_state_t  next_state;
  logic [1:0]  a20_sync;
  logic        smi_pending;
  logic        smi_msg_hit;
  logic [smm_seq_pkg::NUM_SRC-1:0] event_prev;
  logic [smm_seq_pkg::NUM_SRC-1:0] event_rise;
  logic        ph_prev;
  smm_seq_pkg::arch_state_t saved;
  smm_seq_pkg::arch_state_t entry_state;

  // Only SMI messages addressed to this node or broadcast are taken.
  // The global destination is the all-ones code.
  assign smi_msg_hit = msg_i.valid && (msg_i.msg_type == smm_seq_pkg::MSG_SMI) &&
                       (msg_i.dest == node_id_i || msg_i.dest == 8'hff);

  // Local events only request an IO cycle; edges avoid repeated cycles.
  assign event_rise = local_event_i & ~event_prev;

  // Entry image built from the saved copy so untouched fields stay unmodified.
  always_comb begin
    entry_state = saved;
    entry_state.ip = smm_seq_pkg::ENTRY_IP;
    entry_state.cs_sel = region_base_msr_i[smm_seq_pkg::BASE_SEL_HI:
                                           smm_seq_pkg::BASE_SEL_LO];
    entry_state.ds_sel = smm_seq_pkg::ENTRY_DATA_SEL;
    entry_state.es_sel = smm_seq_pkg::ENTRY_DATA_SEL;
    entry_state.ss_sel = smm_seq_pkg::ENTRY_DATA_SEL;
    entry_state.fs_sel = smm_seq_pkg::ENTRY_DATA_SEL;
    entry_state.gs_sel = smm_seq_pkg::ENTRY_DATA_SEL;
    entry_state.flags = smm_seq_pkg::ENTRY_FLAGS;
    entry_state.cr4 = smm_seq_pkg::ENTRY_CR4;
    entry_state.dr7 = smm_seq_pkg::ENTRY_DR7;
    entry_state.cr0[smm_seq_pkg::CR0_PE_POS] = 1'b0;
    entry_state.cr0[smm_seq_pkg::CR0_EM_POS] = 1'b0;
    entry_state.cr0[smm_seq_pkg::CR0_TS_POS] = 1'b0;
    entry_state.cr0[smm_seq_pkg::CR0_PG_POS] = 1'b0;
    entry_state.efer = '0;
    entry_state.efer[smm_seq_pkg::EFER_SVM_POS] =
      saved.efer[smm_seq_pkg::EFER_SVM_POS];
  end

  // Sequencer next state.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:    if (smi_pending) next_state = ST_WAIT;
      ST_WAIT:    if (insn_boundary_i) next_state = ST_SAVE;
      ST_SAVE:    if (save_done_i) next_state = ST_HANDLER;
      ST_HANDLER: if (rsm_exec_i) next_state = ST_RESTORE;
      ST_RESTORE: if (save_done_i) next_state = ST_IDLE;
      default:    next_state = ST_IDLE;
    endcase
  end

  // State register; reset parks the sequencer in idle.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Pending latch; a message in the take cycle wins so none is lost.
  // A message during the handler stays latched and is taken after return.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      smi_pending <= 1'b0;
    end else if (smi_msg_hit) begin
      smi_pending <= 1'b1;
    end else if (state == ST_IDLE && smi_pending) begin
      smi_pending <= 1'b0;
    end
  end

  // Pin synchroniser for the address bit 20 mask input.
  // Only the second stage is read, so a metastable first stage never fans out.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      a20_sync <= 2'b00;
    end else begin
      a20_sync <= {a20_sync[0], address_bit20_mask_pin_i};
    end
  end

  // Snapshot of the interrupted context, held until return.
  // It is taken at the boundary edge so the image matches the interrupted point.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      saved <= '0;
    end else if (state == ST_WAIT && insn_boundary_i) begin
      saved <= core_state_i;
    end
  end

  // Save engine requests and addresses.
  // The whole image moves in one handshake; the engine owns the byte layout.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      save_req_o    <= 1'b0;
      restore_req_o <= 1'b0;
      save_addr_o   <= '0;
      save_state_o  <= '0;
    end else begin
      save_req_o    <= (next_state == ST_SAVE);
      restore_req_o <= (next_state == ST_RESTORE);
      save_addr_o   <= region_base_msr_i +
                       smm_seq_pkg::SAVE_AREA_OFFSET[ADDR_W-1:0];
      save_state_o  <= (state == ST_WAIT) ? core_state_i : saved;
    end
  end

  // Core load: handler image after save, saved image after return.
  // Values stay put after the pulse so the core may sample them late.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_state_o     <= 1'b0;
      load_state_val_o <= '0;
      fetch_addr_o     <= '0;
    end else begin
      load_state_o <= 1'b0;
      if (state == ST_SAVE && save_done_i) begin
        load_state_o     <= 1'b1;
        load_state_val_o <= entry_state;
        fetch_addr_o     <= region_base_msr_i +
                            smm_seq_pkg::HANDLER_OFFSET[ADDR_W-1:0];
      end else if (state == ST_RESTORE && save_done_i) begin
        load_state_o     <= 1'b1;
        load_state_val_o <= restore_state_i;
        fetch_addr_o     <= restore_state_i.ip[ADDR_W-1:0];
      end
    end
  end

  // Operating mode inside management mode.
  // Driven from next_state; the NMI and INIT mask and a20_mask_eff_o switch on entry to save, the rest on the same edge as in_smm_o.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_smm_o          <= 1'b0;
      real_mode_o       <= 1'b0;
      default_16bit_o   <= 1'b0;
      seg_limit_o       <= '0;
      ip_width_sel_o    <= '0;
      far_base_bits_o   <= '0;
      nmi_init_masked_o <= 1'b0;
      real_ivt_sel_o    <= 1'b0;
      a20_mask_eff_o    <= 1'b0;
    end else begin
      in_smm_o          <= (next_state == ST_HANDLER);
      real_mode_o       <= (next_state == ST_HANDLER);
      default_16bit_o   <= (next_state == ST_HANDLER);
      seg_limit_o       <= (next_state == ST_HANDLER) ? smm_seq_pkg::SEG_LIMIT_4G : '0;
      ip_width_sel_o    <= (next_state == ST_HANDLER) ? 5'(smm_seq_pkg::IP_RM_BITS) : '0;
      far_base_bits_o   <= (next_state == ST_HANDLER) ? 5'(smm_seq_pkg::FAR_BASE_BITS) : '0;
      nmi_init_masked_o <= (next_state inside {ST_SAVE, ST_HANDLER, ST_RESTORE});
      real_ivt_sel_o    <= (next_state == ST_HANDLER);
      a20_mask_eff_o    <= (next_state == ST_IDLE || next_state == ST_WAIT) ?
                           a20_sync[1] : 1'b0;
    end
  end

  // Special entry and exit cycles when enabled.
  // Each is a one-cycle pulse; the enable is sampled at the edge that starts it.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      special_enter_o <= 1'b0;
      special_exit_o  <= 1'b0;
    end else begin
      special_enter_o <= special_cycle_en_i && state == ST_WAIT && insn_boundary_i;
      special_exit_o  <= special_cycle_en_i && state == ST_RESTORE && save_done_i;
    end
  end

  // Local events: status bits and IO cycles toward the hub command port.
  // Status is sticky and cleared by the handler's return; a new event wins.
  // A pending or halt event that coincides with a local event is dropped.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_prev         <= '0;
      ph_prev            <= 1'b0;
      local_smi_status_o <= '0;
      io_cycle_o         <= '0;
    end else begin
      event_prev <= local_event_i;
      ph_prev    <= pend_halt_event_i;
      if (state == ST_RESTORE && save_done_i) begin
        local_smi_status_o <= 32'(event_rise);
      end else begin
        local_smi_status_o <= local_smi_status_o | 32'(event_rise);
      end
      io_cycle_o.valid <= 1'b0;
      if (|event_rise) begin
        io_cycle_o.valid <= 1'b1;
        io_cycle_o.port  <= trigger_io_cycle_reg_i[15:0];
        io_cycle_o.data  <= trigger_io_cycle_reg_i[47:16];
      end else if (pend_halt_event_i && !ph_prev) begin
        io_cycle_o.valid <= 1'b1;
        io_cycle_o.port  <= pending_halt_event_reg_i[15:0];
        io_cycle_o.data  <= pending_halt_event_reg_i[47:16];
      end
    end
  end

endmodule

// ### inc/smm_seq_pkg.sv
/*
  Shared constants and carrier types for the management mode sequencer.
  Assumes a 20 MHz core clock and a core pipeline that reports instruction
  boundaries and accepts an architectural state image to load.
*/
package smm_seq_pkg;

  // Offsets from the handler region base.
  localparam logic [31:0] HANDLER_OFFSET   = 32'h0000_8000;
  localparam logic [31:0] SAVE_AREA_FIRST  = 32'h0000_fe00;
  localparam logic [31:0] SAVE_AREA_LAST   = 32'h0000_ffff;
  localparam logic [31:0] SAVE_AREA_OFFSET = 32'h0000_fe00;

  // Initial state values.
  localparam logic [63:0] ENTRY_IP         = 64'h0000_0000_0000_8000;
  localparam logic [63:0] ENTRY_FLAGS      = 64'h0000_0000_0000_0002;
  localparam logic [63:0] ENTRY_CR4        = 64'h0000_0000_0000_0000;
  localparam logic [63:0] ENTRY_DR7        = 64'h0000_0000_0000_0400;
  localparam logic [15:0] ENTRY_DATA_SEL   = 16'h0000;
  localparam logic [31:0] SEG_LIMIT_4G     = 32'hffff_ffff;

  // Field positions.
  localparam int CR0_PE_POS   = 0;
  localparam int CR0_EM_POS   = 2;
  localparam int CR0_TS_POS   = 3;
  localparam int CR0_PG_POS   = 31;
  localparam int EFER_SVM_POS = 12;
  localparam int BASE_SEL_LO  = 4;
  localparam int BASE_SEL_HI  = 19;
  localparam int IP_RM_BITS   = 16;
  localparam int FAR_BASE_BITS = 20;

  // Local trigger sources, one bit each in the local status word.
  localparam int SRC_MCE      = 0;
  localparam int SRC_IO_TRAP  = 1;
  localparam int SRC_MMIO     = 2;
  localparam int SRC_NB_SPARE = 3;
  localparam int SRC_NB_THR   = 4;
  localparam int SRC_LVT      = 5;
  localparam int NUM_SRC      = 6;

  // Interrupt message types from the link.
  localparam logic [2:0] MSG_SMI = 3'h2;

  // Architectural state moved between core and save area.
  typedef struct packed {
    logic [63:0] ip;
    logic [63:0] flags;
    logic [63:0] cr0;
    logic [63:0] cr4;
    logic [63:0] dr7;
    logic [63:0] efer;
    logic [15:0] cs_sel;
    logic [15:0] ds_sel;
    logic [15:0] es_sel;
    logic [15:0] ss_sel;
    logic [15:0] fs_sel;
    logic [15:0] gs_sel;
  } arch_state_t;

  // Incoming interrupt message.
  typedef struct packed {
    logic       valid;
    logic [2:0] msg_type;
    logic [7:0] dest;
  } int_msg_t;

  // Outgoing IO cycle request.
  typedef struct packed {
    logic        valid;
    logic [15:0] port;
    logic [31:0] data;
  } io_cycle_t;

endpackage

// ### verification/smm_seq_checker.sv
/*
  Port assertions for the management mode sequencer.
  Assumes one clock and the active-low asynchronous reset of the sequencer.
*/
`timescale 1ns/100ps
module smm_seq_checker #(
  parameter int ADDR_W = 32
) (
  // Inputs of the sequencer.
  input wire logic                             ref_clk_i,
  input wire logic                             resetn_i,
  input wire logic                             special_cycle_en_i,
  input wire logic [ADDR_W-1:0]                region_base_msr_i,
  input wire logic [smm_seq_pkg::NUM_SRC-1:0]  local_event_i,
  input wire logic                             insn_boundary_i,
  input wire logic                             rsm_exec_i,
  input wire logic                             save_done_i,
  // Outputs of the sequencer.
  input wire logic                             save_req_o,
  input wire logic                             restore_req_o,
  input wire logic [ADDR_W-1:0]                save_addr_o,
  input wire logic                             load_state_o,
  input wire logic [ADDR_W-1:0]                fetch_addr_o,
  input wire logic                             in_smm_o,
  input wire logic                             real_mode_o,
  input wire logic                             default_16bit_o,
  input wire logic [31:0]                      seg_limit_o,
  input wire logic [4:0]                       ip_width_sel_o,
  input wire logic [4:0]                       far_base_bits_o,
  input wire logic                             a20_mask_eff_o,
  input wire logic                             nmi_init_masked_o,
  input wire logic                             real_ivt_sel_o,
  input wire smm_seq_pkg::io_cycle_t           io_cycle_o,
  input wire logic                             special_enter_o
);
  // Everything here is sampled on the core clock and idle in reset.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_entry_at_boundary: assert property ($rose(save_req_o) |-> $past(insn_boundary_i))
    else $error("Save started off an instruction boundary.");
  a_enter_cycle: assert property ($rose(save_req_o) |-> special_enter_o == $past(special_cycle_en_i))
    else $error("Entry cycle does not follow its enable.");
  a_save_then_jump: assert property (load_state_o && in_smm_o |-> $past(save_done_i) && $past(save_req_o))
    else $error("Handler state loaded before the save finished.");
  a_handler_entry: assert property (load_state_o && in_smm_o |-> fetch_addr_o == region_base_msr_i + 32'h8000)
    else $error("Handler fetch address is wrong.");
  a_save_area: assert property (save_req_o |-> save_addr_o == region_base_msr_i + 32'hfe00)
    else $error("Save area address is wrong.");
  a_handler_mode: assert property (in_smm_o |-> real_mode_o && default_16bit_o && real_ivt_sel_o
      && seg_limit_o == 32'hffff_ffff && ip_width_sel_o == 5'h10 && far_base_bits_o == 5'h14
      && !a20_mask_eff_o)
    else $error("Handler mode controls are wrong.");
  a_nmi_masked: assert property (save_req_o || restore_req_o || in_smm_o |-> nmi_init_masked_o)
    else $error("NMI and INIT not masked in management mode.");
  a_return_start: assert property ($rose(restore_req_o) |-> $past(rsm_exec_i) && $past(in_smm_o))
    else $error("Restore started without a return in the handler.");
  a_io_follows_event: assert property ($rose(|local_event_i) |-> ##[1:2] io_cycle_o.valid)
    else $error("Local event raised no trigger cycle.");

  // Main scenarios seen at least once.
  c_entry: cover property ($rose(save_req_o));
  c_return: cover property ($rose(restore_req_o));
  c_io_cycle: cover property (io_cycle_o.valid);
endmodule

bind system_mgmt_mode_sequencer smm_seq_checker #(.ADDR_W(ADDR_W)) u_chk (.ref_clk_i, .resetn_i,
  .special_cycle_en_i, .region_base_msr_i, .local_event_i, .insn_boundary_i, .rsm_exec_i,
  .save_done_i, .save_req_o, .restore_req_o, .save_addr_o, .load_state_o, .fetch_addr_o,
  .in_smm_o, .real_mode_o, .default_16bit_o, .seg_limit_o, .ip_width_sel_o, .far_base_bits_o,
  .a20_mask_eff_o, .nmi_init_masked_o, .real_ivt_sel_o, .io_cycle_o, .special_enter_o);

// ### verification/smm_hub_model.sv
/*
  Fabric and IO hub model that delivers interrupt messages to the core.
  Assumes the bench injects directed messages one cycle at a time.
*/
`timescale 1ns/100ps
module smm_hub_model #(
  parameter logic [15:0] CMD_PORT = 16'h00b2
) (
  // Clock and reset.
  input  wire logic                   ref_clk_i,
  input  wire logic                   resetn_i,
  // Core side and bench side.
  input  wire smm_seq_pkg::io_cycle_t io_cycle_i,
  input  wire smm_seq_pkg::int_msg_t  inject_i,
  input  wire logic                   slow_i,
  // Messages to the core.
  output smm_seq_pkg::int_msg_t       msg_o
);
  logic [3:0] wait_cnt;

  // A command port write comes back as a global SMI after a short or long delay.
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      msg_o    <= '0;
      wait_cnt <= 4'h0;
    end else begin
      // Idle fields toggle so that nothing can lean on stale values.
      msg_o <= inject_i.valid ? inject_i : {1'b0, ~msg_o.msg_type, ~msg_o.dest};
      if (io_cycle_i.valid && io_cycle_i.port == CMD_PORT) begin
        wait_cnt <= slow_i ? 4'h9 : 4'h1;
      end else if (wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end
      if (wait_cnt == 4'h1 && !inject_i.valid) begin
        msg_o <= {1'b1, smm_seq_pkg::MSG_SMI, 8'hff};
      end
    end
  end
endmodule

// ### verification/tb_system_mgmt_mode_sequencer.sv
/*
  Self-checking bench for the management mode sequencer.
  Assumes the hub model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tb_system_mgmt_mode_sequencer;
  typedef struct packed {logic [2:0] mt; logic [7:0] dst; logic spc; logic hit;} row_t;
  localparam row_t ROWS [6] = '{'{3'h2, 8'h05, 1'b1, 1'b1}, '{3'h2, 8'hff, 1'b0, 1'b1},
    '{3'h2, 8'h06, 1'b1, 1'b0}, '{3'h0, 8'hff, 1'b1, 1'b0}, '{3'h4, 8'h05, 1'b1, 1'b0},
    '{3'h7, 8'hff, 1'b0, 1'b0}};
  int miscompares = 0;
  int n_tests = 0;
  logic ref_clk_i = 1'b0, resetn_i = 1'b0, slow = 1'b0, special_cycle_en_i = 1'b1;
  logic pend_halt_event_i = 1'b0, insn_boundary_i = 1'b0, rsm_exec_i = 1'b0;
  logic address_bit20_mask_pin_i = 1'b0, save_done_i = 1'b0;
  logic [7:0] node_id_i = 8'h05;
  logic [31:0] region_base_msr_i = 32'h0003_0000;
  logic [47:0] trigger_io_cycle_reg_i = 48'h1234_5678_00b2;
  logic [47:0] pending_halt_event_reg_i = 48'h0000_0042_00b2;
  logic [5:0] local_event_i = 6'h00;
  smm_seq_pkg::int_msg_t inject = '0, msg_i;
  smm_seq_pkg::arch_state_t core_state_i = '1, restore_state_i = '0, save_state_o;
  smm_seq_pkg::arch_state_t load_state_val_o;
  smm_seq_pkg::io_cycle_t io_cycle_o;
  logic save_req_o, restore_req_o, load_state_o, in_smm_o, real_mode_o, default_16bit_o;
  logic real_ivt_sel_o, a20_mask_eff_o, nmi_init_masked_o, special_enter_o, special_exit_o;
  logic [31:0] save_addr_o, fetch_addr_o, seg_limit_o, local_smi_status_o;
  logic [4:0] ip_width_sel_o, far_base_bits_o;

  system_mgmt_mode_sequencer #(.ADDR_W(32)) u_dut (.ref_clk_i, .resetn_i, .msg_i, .node_id_i,
    .region_base_msr_i, .special_cycle_en_i, .trigger_io_cycle_reg_i, .pending_halt_event_reg_i,
    .local_event_i, .pend_halt_event_i, .insn_boundary_i, .rsm_exec_i, .core_state_i,
    .address_bit20_mask_pin_i, .save_done_i, .restore_state_i, .save_req_o, .restore_req_o,
    .save_addr_o, .save_state_o, .load_state_o, .load_state_val_o, .fetch_addr_o, .in_smm_o,
    .real_mode_o, .default_16bit_o, .seg_limit_o, .ip_width_sel_o, .far_base_bits_o,
    .a20_mask_eff_o, .nmi_init_masked_o, .real_ivt_sel_o, .io_cycle_o, .special_enter_o,
    .special_exit_o, .local_smi_status_o);
  smm_hub_model u_hub (.ref_clk_i, .resetn_i, .io_cycle_i(io_cycle_o), .inject_i(inject),
    .slow_i(slow), .msg_o(msg_i));

  // The 20 MHz core clock.
  always #25 ref_clk_i = ~ref_clk_i;

  // Inputs move 5 ns after the edge so no sampling race can occur.
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #5;
  endtask

  task automatic send(input logic [2:0] mt, input logic [7:0] dst);
    inject = {1'b1, mt, dst};
    tick();
    inject = {1'b0, ~mt, ~dst};
  endtask

  task automatic wait_io();
    for (int k = 0; k < 3 && io_cycle_o.valid !== 1'b1; k++) tick();
  endtask

  // Entry walk; the expected image is built from the live core state.
  task automatic enter_smm(input logic hit);
    smm_seq_pkg::arch_state_t img;
    insn_boundary_i = 1'b1;
    for (int i = 0; i < 20 && save_req_o !== 1'b1; i++) tick();
    insn_boundary_i = 1'b0;
    `CHK("entry", hit, save_req_o)
    if (save_req_o === 1'b1) begin
      `CHK("enter cycle", special_cycle_en_i, special_enter_o)
      `CHK("saved image", core_state_i, save_state_o)
      tick(2);
      `CHK("no early jump", 1'b0, in_smm_o)
      save_done_i = 1'b1;
      tick();
      save_done_i = 1'b0;
      img = core_state_i;
      img.ip = 64'h8000;
      img.flags = 64'h2;
      img.cr0 = core_state_i.cr0 & ~64'h8000_000d;
      img.cr4 = '0;
      img.dr7 = 64'h400;
      img.efer = core_state_i.efer & 64'h1000;
      img.cs_sel = region_base_msr_i[19:4];
      {img.ds_sel, img.es_sel, img.ss_sel, img.fs_sel, img.gs_sel} = '0;
      `CHK("load", 1'b1, load_state_o)
      `CHK("entry image", img, load_state_val_o)
      `CHK("handler", region_base_msr_i + 32'h8000, fetch_addr_o)
    end
  endtask

  task automatic leave_smm();
    rsm_exec_i = 1'b1;
    tick();
    rsm_exec_i = 1'b0;
    `CHK("restore", 1'b1, restore_req_o)
    tick(2);
    save_done_i = 1'b1;
    tick();
    save_done_i = 1'b0;
    `CHK("restored", restore_state_i, load_state_val_o)
    `CHK("resume", restore_state_i.ip[31:0], fetch_addr_o)
    `CHK("exit cycle", special_cycle_en_i, special_exit_o)
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence: reset, table of messages, then the awkward cases.
  initial begin
    tick(8);
    `CHK("reset mode", 1'b0, in_smm_o)
    resetn_i = 1'b1;
    tick();
    foreach (ROWS[i]) begin
      special_cycle_en_i = ROWS[i].spc;
      region_base_msr_i = {8'h00, 8'(i + 3), 16'h0000};
      core_state_i = {60{8'hf0 | 8'(i)}};
      restore_state_i = ~core_state_i;
      send(ROWS[i].mt, ROWS[i].dst);
      enter_smm(ROWS[i].hit);
      if (ROWS[i].hit) leave_smm();
    end
    send(3'h2, 8'hff);
    tick(6);
    `CHK("no boundary", 1'b0, save_req_o)
    enter_smm(1'b1);
    address_bit20_mask_pin_i = 1'b1;
    send(3'h2, 8'h05);
    insn_boundary_i = 1'b1;
    tick(6);
    `CHK("mask ignored", 1'b0, a20_mask_eff_o)
    `CHK("held in mode", 1'b0, save_req_o)
    leave_smm();
    `CHK("mask outside", 1'b1, a20_mask_eff_o)
    enter_smm(1'b1);
    leave_smm();
    for (int s = 0; s < 6; s++) begin
      slow = s[0];
      local_event_i[s] = 1'b1;
      tick();
      wait_io();
      `CHK("io port", trigger_io_cycle_reg_i[15:0], io_cycle_o.port)
      `CHK("io data", trigger_io_cycle_reg_i[47:16], io_cycle_o.data)
      `CHK("status", 32'((2 << s) - 1), local_smi_status_o)
      local_event_i[s] = 1'b0;
      tick(12);
    end
    pend_halt_event_i = 1'b1;
    tick();
    wait_io();
    `CHK("halt io data", pending_halt_event_reg_i[47:16], io_cycle_o.data)
    pend_halt_event_i = 1'b0;
    tick(12);
    {pend_halt_event_i, local_event_i[0]} = 2'b11;
    tick();
    wait_io();
    `CHK("halt loses", trigger_io_cycle_reg_i[47:16], io_cycle_o.data)
    {pend_halt_event_i, local_event_i[0]} = 2'b00;
    tick(12);
    enter_smm(1'b1);
    leave_smm();
    test_done();
  end

  // Watchdog: the sequence needs well under 1500 cycles.
  initial begin
    #(3000 * 50);
    miscompares++;
    test_done();
  end
endmodule
